// File: drive_self_test.sv
// Drive health monitor: failure history, thermal watch and self-test sequencer
`timescale 1ns/10ps
`default_nettype none
module drive_self_test #(
   parameter int ATTRS = 4,
   parameter int CNT_W = 8,
   parameter longint unsigned TEMP_INTERVAL_CYC = health_pkg::TEMP_INTERVAL_CYC,
   parameter longint unsigned SHORT_BUDGET_CYC = health_pkg::SHORT_BUDGET_CYC,
   parameter logic [31:0] EXT_DURATION_S = 32'h0000_4650
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Error-rate monitoring; op_i, err_i and predict_fail_o carry one bit per attribute
   input wire logic [ATTRS-1:0] op_i,
   input wire logic [ATTRS-1:0] err_i,
   input wire logic [CNT_W-1:0] interval_ops_i,
   input wire logic [CNT_W-1:0] err_thresh_i,
   output logic [ATTRS*CNT_W-1:0] history_o,
   output logic [ATTRS-1:0] predict_fail_o,
   // Informational exceptions control
   input wire logic exceptions_disable_i,
   input wire logic temperature_warning_enable_i,
   input wire logic [3:0] exception_report_method_i,
   input wire logic sticky_predict_i,
   output logic [23:0] exception_sense_o,
   output logic exception_valid_o,
   // Temperature
   input wire logic [7:0] temp_i,
   output logic temp_warn_o,
   output logic snapshot_req_o,
   input wire logic snapshot_ack_i,
   // Configured constants
   output logic [7:0] predict_thresh_o,
   output logic [7:0] temp_limit_o,
   // Readiness
   input wire logic motor_fault_i,
   input wire logic servo_fault_i,
   input wire logic table_fault_i,
   input wire logic manual_start_i,
   output logic not_ready_o,
   output logic [23:0] ready_sense_o,
   // Diagnostic command
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_byte1_i,
   input wire logic bus_reset_i,
   output logic cmd_ready_o,
   output logic busy_o,
   output logic [2:0] cur_func_o,
   output logic [31:0] ext_duration_o,
   // Test engine segments
   output logic seg_start_o,
   output logic [1:0] seg_sel_o,
   output logic full_scan_o,
   input wire logic seg_done_i,
   input wire logic seg_fail_i,
   input wire logic seg_recovered_i,
   input wire logic [31:0] fail_lba_i,
   input wire logic [23:0] fail_sense_i,
   input wire logic [7:0] replaceable_unit_code_i,
   // Results log and its non-volatile commit
   input wire logic [4:0] log_idx_i,
   output logic [health_pkg::ENTRY_W-1:0] log_data_o,
   output logic nv_commit_o,
   input wire logic nv_done_i
);
   initial begin
      if (ATTRS < 1 || CNT_W < 2 || CNT_W > 8) $error("drive_self_test: bad widths");
   end

   // Reset release through two flops
   logic rst_s1_r;
   logic rst_n;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // Configurable constants held after reset
   logic [7:0] predict_thresh_r;
   logic [7:0] temp_limit_r;
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         predict_thresh_r <= health_pkg::PREDICT_THRESH_RST;
         temp_limit_r <= health_pkg::TEMP_LIMIT_RST;
      end
   end
   assign predict_thresh_o = predict_thresh_r;
   assign temp_limit_o = temp_limit_r;

   // Per-attribute rate monitoring
   logic smart_on;
   assign smart_on = !exceptions_disable_i;
   for (genvar a = 0; a < ATTRS; a++) begin : g_attr
      logic [CNT_W-1:0] ops_r;
      logic [CNT_W-1:0] errs_r;
      logic [CNT_W-1:0] hist_r;
      logic [CNT_W-1:0] ops_nxt;
      logic [CNT_W-1:0] errs_nxt;
      logic int_end;
      logic bad;
      assign ops_nxt = ops_r + CNT_W'(op_i[a]);
      assign errs_nxt = (errs_r == '1) ? errs_r : errs_r + CNT_W'(err_i[a]);
      assign int_end = smart_on && op_i[a] && (ops_nxt >= interval_ops_i);
      assign bad = errs_nxt > err_thresh_i;
      always_ff @(posedge ref_clk_i or negedge rst_n) begin
         if (!rst_n) begin
            ops_r <= '0;
            errs_r <= '0;
         end else if (int_end) begin
            ops_r <= '0;
            errs_r <= '0;
         end else if (smart_on) begin
            ops_r <= ops_nxt;
            errs_r <= errs_nxt;
         end
      end
      always_ff @(posedge ref_clk_i or negedge rst_n) begin
         if (!rst_n) begin
            hist_r <= '0;
         end else if (int_end && bad && hist_r != '1) begin
            hist_r <= hist_r + 1'b1;
         end else if (int_end && !bad && hist_r != '0) begin
            hist_r <= hist_r - 1'b1;
         end
      end
      assign history_o[a*CNT_W +: CNT_W] = hist_r;
      assign predict_fail_o[a] = smart_on && (8'(hist_r) >= predict_thresh_r);
   end

   // Thermal sampling timer; first sample right after reset
   logic [39:0] temp_cnt_r;
   logic temp_tick;
   assign temp_tick = (temp_cnt_r == 40'h0);
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         temp_cnt_r <= 40'h0;
      end else if (temp_tick) begin
         temp_cnt_r <= 40'(TEMP_INTERVAL_CYC - 1);
      end else begin
         temp_cnt_r <= temp_cnt_r - 40'h1;
      end
   end

   logic temp_warn_r;
   logic snapshot_r;
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         temp_warn_r <= 1'b0;
      end else if (temp_tick) begin
         temp_warn_r <= temperature_warning_enable_i && smart_on && (temp_i > temp_limit_r);
      end
   end
   // snapshot request, set wins over ack
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         snapshot_r <= 1'b0;
      end else if (temp_tick && smart_on && temp_i > temp_limit_r) begin
         snapshot_r <= 1'b1;
      end else if (snapshot_ack_i) begin
         snapshot_r <= 1'b0;
      end
   end
   assign temp_warn_o = temp_warn_r;
   assign snapshot_req_o = snapshot_r;

   // Exception sense selection; predictive failure is retained by the caller
   // across power cycles through sticky_predict_i, since this logic has no storage of its own
   logic [23:0] exc_sense_r;
   logic exc_valid_r;
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         exc_sense_r <= health_pkg::SENSE_NONE;
         exc_valid_r <= 1'b0;
      end else if (exception_report_method_i == health_pkg::METHOD_REPORT
                   && ((|predict_fail_o) || sticky_predict_i)) begin
         exc_sense_r <= health_pkg::SENSE_PREDICT;
         exc_valid_r <= 1'b1;
      end else if (temp_warn_r && exception_report_method_i != 4'h0) begin
         exc_sense_r <= health_pkg::SENSE_TEMP;
         exc_valid_r <= 1'b1;
      end else begin
         exc_sense_r <= health_pkg::SENSE_NONE;
         exc_valid_r <= 1'b0;
      end
   end
   assign exception_sense_o = exc_sense_r;
   assign exception_valid_o = exc_valid_r;

   logic [23:0] ready_sense_r;
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ready_sense_r <= health_pkg::SENSE_NONE;
      end else if (motor_fault_i || servo_fault_i || table_fault_i) begin
         ready_sense_r <= manual_start_i ? health_pkg::SENSE_NOT_READY_MAN
                                         : health_pkg::SENSE_NOT_READY;
      end else begin
         ready_sense_r <= health_pkg::SENSE_NONE;
      end
   end
   assign ready_sense_o = ready_sense_r;
   assign not_ready_o = (ready_sense_r != health_pkg::SENSE_NONE);

   // Self-test sequencer
   health_pkg::dst_state_type state_r;
   logic [2:0] func_r;
   logic [3:0] result_r;
   logic [31:0] lba_r;
   logic [23:0] sense_r;
   logic [7:0] unit_r;
   logic [39:0] budget_r;
   logic nv_wait_r;
   logic [2:0] cmd_func;
   logic start_ok;
   logic host_abort;
   logic reset_abort;
   logic budget_over;
   assign cmd_func = cmd_byte1_i[health_pkg::FUNC_MSB:health_pkg::FUNC_LSB];
   assign start_ok = cmd_valid_i && !not_ready_o && state_r == health_pkg::ST_IDLE
                     && (cmd_func == health_pkg::FUNC_SHORT
                         || cmd_func == health_pkg::FUNC_EXTENDED);
   assign host_abort = cmd_valid_i && cmd_func == health_pkg::FUNC_ABORT;
   assign reset_abort = bus_reset_i;
   assign budget_over = func_r == health_pkg::FUNC_SHORT && budget_r == 40'h0;
   assign cmd_ready_o = (state_r == health_pkg::ST_IDLE) || cmd_func == health_pkg::FUNC_ABORT;
   assign busy_o = state_r != health_pkg::ST_IDLE;
   assign cur_func_o = func_r;
   assign ext_duration_o = EXT_DURATION_S;

   logic in_seg;
   assign in_seg = state_r == health_pkg::ST_ELEC || state_r == health_pkg::ST_SERVO
                   || state_r == health_pkg::ST_SCAN;
   logic seg_bad;
   assign seg_bad = seg_done_i && seg_fail_i && !seg_recovered_i;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= health_pkg::ST_IDLE;
         func_r <= 3'h0;
         result_r <= health_pkg::RES_PASS;
         lba_r <= 32'h0;
         sense_r <= health_pkg::SENSE_NONE;
         unit_r <= 8'h0;
      end else begin
         unique case (state_r)
            health_pkg::ST_IDLE: begin
               if (start_ok) begin
                  func_r <= cmd_func;
                  result_r <= health_pkg::RES_RUNNING;
                  lba_r <= 32'h0;
                  sense_r <= health_pkg::SENSE_NONE;
                  unit_r <= 8'h0;
                  state_r <= health_pkg::ST_OPEN;
               end
            end
            health_pkg::ST_OPEN: begin
               if (nv_done_i) state_r <= health_pkg::ST_ELEC;
            end
            health_pkg::ST_ELEC, health_pkg::ST_SERVO, health_pkg::ST_SCAN: begin
               if (reset_abort) begin
                  result_r <= health_pkg::RES_ABORT_RESET;
                  state_r <= health_pkg::ST_CLOSE;
               end else if (host_abort) begin
                  result_r <= health_pkg::RES_ABORT_HOST;
                  state_r <= health_pkg::ST_CLOSE;
               end else if (seg_bad) begin
                  result_r <= state_r == health_pkg::ST_ELEC ? health_pkg::RES_FAIL_ELEC :
                              state_r == health_pkg::ST_SERVO ? health_pkg::RES_FAIL_SERVO :
                              health_pkg::RES_FAIL_SCAN;
                  lba_r <= state_r == health_pkg::ST_SCAN ? fail_lba_i : 32'hFFFF_FFFF;
                  sense_r <= fail_sense_i;
                  unit_r <= replaceable_unit_code_i;
                  state_r <= health_pkg::ST_CLOSE;
               end else if (state_r == health_pkg::ST_SCAN && (seg_done_i || budget_over)) begin
                  result_r <= health_pkg::RES_PASS;
                  state_r <= health_pkg::ST_CLOSE;
               end else if (seg_done_i) begin
                  state_r <= state_r == health_pkg::ST_ELEC ? health_pkg::ST_SERVO
                                                            : health_pkg::ST_SCAN;
               end
            end
            health_pkg::ST_CLOSE: begin
               if (nv_done_i && nv_wait_r) state_r <= health_pkg::ST_IDLE;
            end
            default: state_r <= health_pkg::ST_IDLE;
         endcase
      end
   end

   // Short budget countdown from the start of the test
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         budget_r <= 40'h0;
      end else if (start_ok) begin
         budget_r <= 40'(SHORT_BUDGET_CYC - 1);
      end else if (budget_r != 40'h0) begin
         budget_r <= budget_r - 40'h1;
      end
   end

   // Segment launch, one pulse on entry to each segment
   health_pkg::dst_state_type prev_state_r;
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prev_state_r <= health_pkg::ST_IDLE;
      end else begin
         prev_state_r <= state_r;
      end
   end
   assign seg_start_o = in_seg && prev_state_r != state_r;
   assign seg_sel_o = state_r == health_pkg::ST_ELEC ? 2'h0 :
                      state_r == health_pkg::ST_SERVO ? 2'h1 : 2'h2;
   assign full_scan_o = func_r == health_pkg::FUNC_EXTENDED;

   // Log writes: push on start, rewrite head on close, commit after each
   logic log_push;
   logic log_head_wr;
   logic [health_pkg::ENTRY_W-1:0] entry;
   assign log_push = start_ok;
   assign log_head_wr = state_r == health_pkg::ST_CLOSE && !nv_wait_r;
   assign entry = {func_r, result_r, lba_r, sense_r, unit_r};

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         nv_wait_r <= 1'b0;
      end else if (log_head_wr) begin
         nv_wait_r <= 1'b1;
      end else if (state_r == health_pkg::ST_IDLE) begin
         nv_wait_r <= 1'b0;
      end
   end
   assign nv_commit_o = state_r == health_pkg::ST_OPEN || (state_r == health_pkg::ST_CLOSE && nv_wait_r);

   result_log_mem #(
      .DEPTH(health_pkg::LOG_DEPTH),
      .WIDTH(health_pkg::ENTRY_W)
   ) u_log (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .push_i(log_push),
      .push_data_i({cmd_func, health_pkg::RES_RUNNING, 32'h0, health_pkg::SENSE_NONE, 8'h0}),
      .head_wr_i(log_head_wr),
      .head_data_i(entry),
      .rd_idx_i(log_idx_i),
      .rd_data_o(log_data_o)
   );
endmodule // drive_self_test
`default_nettype wire

// File: drive_self_test_tb.sv
// Self-checking bench for the drive health monitor
`timescale 1ns/10ps
`default_nettype none
module drive_self_test_tb;
   localparam logic [31:0] EXT_S = 32'h0000_0123;
   logic ref_clk_i = 0, rstn_i = 0, exceptions_disable_i = 0, sticky_predict_i = 0;
   logic temperature_warning_enable_i = 1, motor_fault_i = 0, servo_fault_i = 0;
   logic table_fault_i = 0, manual_start_i = 0, cmd_valid_i = 0, bus_reset_i = 0, recov = 0;
   logic snapshot_ack_i, seg_done_i, seg_fail_i, seg_recovered_i, nv_done_i, temp_warn_o;
   logic snapshot_req_o, not_ready_o, cmd_ready_o, busy_o, seg_start_o, full_scan_o;
   logic nv_commit_o, exception_valid_o;
   logic [3:0] op_i = 0, err_i = 0, predict_fail_o, exception_report_method_i = 4'h1;
   logic [7:0] interval_ops_i = 8'h04, err_thresh_i = 8'h01, temp_i = 8'h50, cmd_byte1_i = 0;
   logic [7:0] replaceable_unit_code_i, predict_thresh_o, temp_limit_o;
   logic [31:0] history_o, fail_lba_i, ext_duration_o;
   logic [23:0] exception_sense_o, ready_sense_o, fail_sense_i;
   logic [2:0] cur_func_o;
   logic [1:0] seg_sel_o, fail_seg = 2'h3;
   logic [4:0] log_idx_i = 0;
   logic [70:0] log_data_o, d;
   int err_total = 0, n_tests = 0;
   drive_self_test #(.TEMP_INTERVAL_CYC(50), .SHORT_BUDGET_CYC(20), .EXT_DURATION_S(EXT_S))
   dut_u (.ref_clk_i, .rstn_i, .op_i, .err_i, .interval_ops_i, .err_thresh_i, .history_o,
      .predict_fail_o, .exceptions_disable_i, .temperature_warning_enable_i,
      .exception_report_method_i, .sticky_predict_i, .exception_sense_o, .exception_valid_o,
      .temp_i, .temp_warn_o, .snapshot_req_o, .snapshot_ack_i, .predict_thresh_o, .temp_limit_o,
      .motor_fault_i, .servo_fault_i, .table_fault_i, .manual_start_i, .not_ready_o,
      .ready_sense_o, .cmd_valid_i, .cmd_byte1_i, .bus_reset_i, .cmd_ready_o, .busy_o,
      .cur_func_o, .ext_duration_o, .seg_start_o, .seg_sel_o, .full_scan_o, .seg_done_i,
      .seg_fail_i, .seg_recovered_i, .fail_lba_i, .fail_sense_i, .replaceable_unit_code_i,
      .log_idx_i, .log_data_o, .nv_commit_o, .nv_done_i);
   seg_engine_model eng_u (.clk_i(ref_clk_i), .rstn_i(rstn_i), .seg_start_i(seg_start_o),
      .nv_commit_i(nv_commit_o), .snapshot_req_i(snapshot_req_o), .recov_i(recov),
      .seg_sel_i(seg_sel_o), .fail_seg_i(fail_seg), .seg_done_o(seg_done_i),
      .seg_fail_o(seg_fail_i), .seg_recovered_o(seg_recovered_i), .nv_done_o(nv_done_i),
      .snapshot_ack_o(snapshot_ack_i), .lba_o(fail_lba_i), .sense_o(fail_sense_i),
      .unit_o(replaceable_unit_code_i));
   initial begin
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   task automatic check(input logic [70:0] seen, input logic [70:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #10;
   endtask
   task automatic send(input logic [7:0] b);
      cmd_byte1_i = b;
      cmd_valid_i = 1'b1;
      cyc(1);
      cmd_valid_i = 1'b0;
   endtask
   task automatic interval(input int a, input int nerr);
      for (int i = 0; i < 4; i++) begin
         op_i = 4'h1 << a;
         err_i = (i < nerr) ? op_i : 4'h0;
         cyc(1);
      end
      op_i = 4'h0;
      err_i = 4'h0;
      cyc(3);
   endtask
   task automatic read_log(input logic [4:0] idx);
      log_idx_i = idx;
      cyc(2);
      d = log_data_o;
   endtask
   // stop: 0 runs to the end, 1 host abort, 2 bus reset
   task automatic run_test(input logic [2:0] f, input int stop, input logic [3:0] res);
      send({f, 5'h00});
      read_log(0);
      check(d[70:64], {f, 4'hF});
      check({busy_o, cmd_ready_o}, 2'h2);
      if (stop != 0) begin
         for (int i = 0; i < 20 && seg_start_o !== 1'b1; i++) cyc(1);
         check(seg_start_o, 1'b1);
         cyc(2);
         if (stop == 1) send(8'h80);
         else bus_reset_i = 1'b1;
         cyc(1);
         bus_reset_i = 1'b0;
      end
      for (int i = 0; i < 100 && busy_o !== 1'b0; i++) cyc(1);
      check({busy_o, cmd_ready_o}, 2'h1);
      read_log(0);
      check(d[70:64], {f, res});
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      cyc(8);
      rstn_i = 1'b1;
      cyc(4);
      check(predict_thresh_o, 8'h10);
      check(temp_limit_o, 8'h3C);
      check(ext_duration_o, EXT_S);
      check(temp_warn_o, 1'b1);
      check(exception_sense_o, health_pkg::SENSE_TEMP);
      check({exception_valid_o, snapshot_req_o}, 2'h3);
      // Equal to the limit is not over it
      temp_i = 8'h3C;
      cyc(55);
      check(temp_warn_o, 1'b0);
      temperature_warning_enable_i = 1'b0;
      temp_i = 8'h50;
      cyc(50);
      check(temp_warn_o, 1'b0);
      temperature_warning_enable_i = 1'b1;
      temp_i = 8'h3C;
      interval(0, 0);
      check(history_o, 32'h0);
      repeat (16) interval(0, 2);
      check(history_o, 32'h10);
      check(predict_fail_o, 4'h1);
      check(exception_sense_o, health_pkg::SENSE_PREDICT);
      exception_report_method_i = 4'h0;
      cyc(2);
      check(exception_valid_o, 1'b0);
      exception_report_method_i = 4'h1;
      interval(0, 1);
      interval(1, 2);
      check(history_o, 32'h010F);
      check(predict_fail_o, 4'h0);
      sticky_predict_i = 1'b1;
      cyc(2);
      check(exception_sense_o, health_pkg::SENSE_PREDICT);
      sticky_predict_i = 1'b0;
      for (int k = 0; k < 4; k++) begin
         {motor_fault_i, servo_fault_i, table_fault_i} = 3'h4 >> k[1:0];
         manual_start_i = k == 3;
         if (k == 3) table_fault_i = 1'b1;
         cyc(3);
         check(ready_sense_o, k == 3 ? 24'h020403 : 24'h020400);
         check(not_ready_o, 1'b1);
         send(8'h20);
         cyc(2);
         check(busy_o, 1'b0);
      end
      {table_fault_i, manual_start_i} = 2'h0;
      cyc(2);
      send(8'h60);
      cyc(2);
      check(busy_o, 1'b0);
      run_test(3'h2, 0, 4'h0);
      fail_seg = 2'h0;
      run_test(3'h1, 0, 4'h3);
      fail_seg = 2'h2;
      run_test(3'h2, 0, 4'h7);
      check(d[63:0], {32'h0000_1234, 24'h031100, 8'h5A});
      fail_seg = 2'h3;
      run_test(3'h1, 1, 4'h1);
      run_test(3'h2, 2, 4'h2);
      fail_seg = 2'h2;
      run_test(3'h1, 0, 4'h0);
      fail_seg = 2'h1;
      recov = 1'b1;
      run_test(3'h1, 0, 4'h0);
      for (int i = 0; i < 13; i++) run_test(3'h1, 0, 4'h0);
      read_log(19);
      check(d[70:64], 7'h20);
      run_test(3'h1, 0, 4'h0);
      read_log(19);
      check(d[70:68], 3'h1);
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      complete_run();
   end
endmodule // drive_self_test_tb
`default_nettype wire

// File: dst_assertions.sv
// Port assertions for the drive health monitor
`timescale 1ns/10ps
`default_nettype none
module dst_checker #(parameter int ATTRS = 4, parameter int CNT_W = 8) (
   // Clock, reset and inputs
   input wire logic ref_clk_i, rstn_i, cmd_valid_i, bus_reset_i, nv_done_i,
   input wire logic seg_done_i, seg_fail_i, seg_recovered_i, exceptions_disable_i,
   input wire logic [7:0] cmd_byte1_i,
   // Outputs
   input wire logic busy_o, nv_commit_o, seg_start_o, full_scan_o, not_ready_o,
   input wire logic temp_warn_o, snapshot_req_o,
   input wire logic [7:0] predict_thresh_o,
   input wire logic [1:0] seg_sel_o,
   input wire logic [2:0] cur_func_o,
   input wire logic [ATTRS-1:0] predict_fail_o,
   input wire logic [ATTRS*CNT_W-1:0] history_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   logic in_seg;
   logic [CNT_W-1:0] h0;
   assign in_seg = busy_o && !nv_commit_o;
   assign h0 = history_o[CNT_W-1:0];
   a_start_commit: assert property (cmd_valid_i && !busy_o && !not_ready_o
      && cmd_byte1_i[7:5] inside {3'h1, 3'h2} |=> busy_o && nv_commit_o) else $error("no commit");
   a_commit_hold: assert property (nv_commit_o && !nv_done_i |=> nv_commit_o)
      else $error("commit dropped");
   a_seg_order: assert property (seg_done_i && !seg_fail_i && in_seg && !bus_reset_i
      && seg_sel_o == 2'h0 |=> seg_start_o && seg_sel_o == 2'h1) else $error("bad order");
   a_fail_close: assert property (seg_done_i && seg_fail_i && !seg_recovered_i && in_seg
      |-> ##[1:2] nv_commit_o) else $error("failure not closed");
   a_abort_close: assert property (in_seg && (bus_reset_i || cmd_valid_i
      && cmd_byte1_i[7:5] == 3'h4) |-> ##[1:2] nv_commit_o) else $error("abort not closed");
   a_scan_depth: assert property (seg_start_o && seg_sel_o == 2'h2
      |-> full_scan_o == (cur_func_o == 3'h2)) else $error("scan depth wrong");
   a_predict_level: assert property (predict_fail_o[0] ==
      (h0 >= predict_thresh_o && !exceptions_disable_i)) else $error("predict wrong");
   a_history_step: assert property ($changed(h0) |->
      h0 == $past(h0) + 1'b1 || h0 == $past(h0) - 1'b1) else $error("history jump");
   a_refuse_unready: assert property (not_ready_o && cmd_valid_i && !busy_o
      |=> !busy_o) else $error("started while not ready");
   a_snapshot_req: assert property ($rose(temp_warn_o) |-> ##[0:1] snapshot_req_o)
      else $error("no snapshot");
endmodule // dst_checker
bind drive_self_test dst_checker #(.ATTRS(ATTRS), .CNT_W(CNT_W)) chk_u (.ref_clk_i, .rstn_i,
   .cmd_valid_i, .bus_reset_i, .nv_done_i, .seg_done_i, .seg_fail_i, .seg_recovered_i,
   .exceptions_disable_i,
   .cmd_byte1_i, .busy_o, .nv_commit_o, .seg_start_o, .full_scan_o, .not_ready_o, .temp_warn_o,
   .snapshot_req_o, .predict_thresh_o, .seg_sel_o, .cur_func_o, .predict_fail_o, .history_o);
`default_nettype wire

// File: health_pkg.sv
// Constants and types shared by the drive health monitor and its result log
package health_pkg;
   // Temperature sampling: ten minutes at 10 MHz
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned TEMP_INTERVAL_S = 600;
   localparam longint unsigned TEMP_INTERVAL_CYC = longint'(TEMP_INTERVAL_S) * CLK_HZ;
   // Short test budget in seconds
   localparam int unsigned SHORT_BUDGET_S = 120;
   localparam longint unsigned SHORT_BUDGET_CYC = longint'(SHORT_BUDGET_S) * CLK_HZ;
   // Function codes, command byte 1 bits 7:5
   localparam int FUNC_MSB = 7;
   localparam int FUNC_LSB = 5;
   localparam logic [2:0] FUNC_SHORT = 3'h1;
   localparam logic [2:0] FUNC_EXTENDED = 3'h2;
   localparam logic [2:0] FUNC_ABORT = 3'h4;
   // Result values
   localparam logic [3:0] RES_PASS = 4'h0;
   localparam logic [3:0] RES_ABORT_HOST = 4'h1;
   localparam logic [3:0] RES_ABORT_RESET = 4'h2;
   localparam logic [3:0] RES_FAIL_ELEC = 4'h3;
   localparam logic [3:0] RES_FAIL_SERVO = 4'h4;
   localparam logic [3:0] RES_FAIL_SCAN = 4'h7;
   localparam logic [3:0] RES_RUNNING = 4'hF;
   // Sense codes: key, ASC, ASCQ
   localparam logic [23:0] SENSE_NONE = 24'h000000;
   localparam logic [23:0] SENSE_TEMP = 24'h010B01;
   localparam logic [23:0] SENSE_PREDICT = 24'h015D00;
   localparam logic [23:0] SENSE_NOT_READY = 24'h020400;
   localparam logic [23:0] SENSE_NOT_READY_MAN = 24'h020403;
   localparam logic [23:0] SENSE_MEDIUM_ERR = 24'h031100;
   localparam logic [23:0] SENSE_HW_ERR = 24'h040000;
   // Method value that reports predictive failures to the host
   localparam logic [3:0] METHOD_REPORT = 4'h1;
   // Informational exceptions control page code
   localparam logic [7:0] IEC_PAGE = 8'h1C;
   // Log geometry and entry layout
   localparam int LOG_DEPTH = 20;
   localparam int ENTRY_W = 3 + 4 + 32 + 24 + 8;
   // Defaults loaded at reset
   localparam logic [7:0] PREDICT_THRESH_RST = 8'h10;
   localparam logic [7:0] TEMP_LIMIT_RST = 8'h3C;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPEN = 3'b001,
      ST_ELEC = 3'b011,
      ST_SERVO = 3'b010,
      ST_SCAN = 3'b110,
      ST_CLOSE = 3'b111
   } dst_state_type;
endpackage

// File: result_log_mem.sv
// Self-test results log: shift-in-at-head store with registered read and head rewrite
`timescale 1ns/10ps
`default_nettype none
module result_log_mem #(
   parameter int DEPTH = 20,
   parameter int WIDTH = 71
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Insert at head, shifting older entries down
   input wire logic push_i,
   input wire logic [WIDTH-1:0] push_data_i,
   // Rewrite of the head entry
   input wire logic head_wr_i,
   input wire logic [WIDTH-1:0] head_data_i,
   // Read port
   input wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
   output logic [WIDTH-1:0] rd_data_o
);
   initial begin
      if (DEPTH < 2 || WIDTH < 1) $error("result_log_mem: bad geometry");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];

   // Oldest entry falls off the end on overflow
   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            mem_r[g] <= '0;
         end else if (push_i) begin
            if (g == 0) begin
               mem_r[g] <= push_data_i;
            end else begin
               mem_r[g] <= mem_r[g > 0 ? g - 1 : 0];
            end
         end else if (head_wr_i && g == 0) begin
            mem_r[g] <= head_data_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= '0;
      end else if (32'(rd_idx_i) < DEPTH) begin
         rd_data_o <= mem_r[rd_idx_i];
      end else begin
         rd_data_o <= '0;
      end
   end
endmodule // result_log_mem
`default_nettype wire

// File: seg_engine_model.sv
// Test engine and non-volatile store stand-in for the self-test sequencer
`timescale 1ns/10ps
`default_nettype none
module seg_engine_model (
   // Clock and reset
   input wire logic clk_i, rstn_i,
   // Requests and scenario controls
   input wire logic seg_start_i, nv_commit_i, snapshot_req_i, recov_i,
   input wire logic [1:0] seg_sel_i, fail_seg_i,
   // Answers
   output logic seg_done_o, seg_fail_o, seg_recovered_o, nv_done_o, snapshot_ack_o,
   output logic [31:0] lba_o,
   output logic [23:0] sense_o,
   output logic [7:0] unit_o
);
   logic [2:0] seg_cnt_r, nv_cnt_r;
   logic [1:0] sel_r;
   logic [7:0] tick_r;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {seg_cnt_r, nv_cnt_r, sel_r, tick_r} <= '0;
         {seg_done_o, nv_done_o, snapshot_ack_o} <= 3'h0;
      end else begin
         tick_r <= tick_r + 8'h01;
         seg_done_o <= seg_cnt_r == 3'h1;
         seg_cnt_r <= seg_start_i ? 3'h5 : seg_cnt_r - {2'h0, seg_cnt_r != 3'h0};
         if (seg_start_i) sel_r <= seg_sel_i;
         // No second answer while the sequencer is still leaving the commit
         nv_done_o <= nv_cnt_r == 3'h1;
         nv_cnt_r <= (nv_commit_i && nv_cnt_r == 3'h0 && !nv_done_o) ? 3'h3
            : nv_cnt_r - {2'h0, nv_cnt_r != 3'h0};
         snapshot_ack_o <= snapshot_req_i && !snapshot_ack_o;
      end
   end
   // chosen segment reports an error; recov_i makes retries recover it
   assign seg_fail_o = seg_done_o && sel_r == fail_seg_i;
   assign seg_recovered_o = seg_fail_o && recov_i;
   // Details hold only with the done pulse, a moving pattern otherwise
   assign lba_o = seg_done_o ? 32'h0000_1234 : {4{tick_r}};
   assign sense_o = seg_done_o ? 24'h031100 : {3{~tick_r}};
   assign unit_o = seg_done_o ? 8'h5A : tick_r;
endmodule // seg_engine_model
`default_nettype wire
